// File: ltfu_core.sv
// linear texel fetch unit: attach commands, checks, address generation and fetch
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module ltfu_core
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // store directory answers combinationally for the name on store_query_name
   output logic [31:0] store_query_name,
   input wire logic store_exists,
   input wire logic [31:0] store_size,
   // fetch request and answer
   input wire logic fetch_req,
   input wire logic [31:0] fetch_index,
   output logic fetch_valid,
   output logic [127:0] fetch_rgba,
   output logic [1:0] fetch_kind,
   // byte-address word read port of the store, one-cycle latency
   output logic mem_rd,
   output logic [31:0] mem_addr,
   input wire logic [31:0] mem_rdata
);
   import ltfu_pkg::*;

   // ==========================================================
   // register file
   logic [31:0] name_reg_r, name_reg_nxt, off_reg_r, off_reg_nxt, len_reg_r, len_reg_nxt;
   logic [31:0] bind_r, bind_nxt;
   logic [31:0] att_name_r, att_name_nxt, att_off_r, att_off_nxt, att_len_r, att_len_nxt;
   logic [4:0] att_fmt_r, att_fmt_nxt;
   logic attached_r, attached_nxt;
   logic [31:0] count_r, count_nxt;
   logic [1:0] err_r, err_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic go, whole, fmt_ok, sz_ok;
   logic [3:0] target;
   logic [4:0] fmt;
   logic [31:0] eff_off, eff_len;
   logic [32:0] end_sum;
   logic [31:0] raw_count;

   function automatic logic [2:0] ltfu_esize(input logic [2:0] t);
      unique case (t)
         LTFU_T_UB_NORM, LTFU_T_BYTE: ltfu_esize = 3'd1;
         LTFU_T_US_NORM, LTFU_T_HALF, LTFU_T_SHORT: ltfu_esize = 3'd2;
         default: ltfu_esize = 3'd4;
      endcase
   endfunction : ltfu_esize

   // only the 32-bit unsigned integer type has a type code of its own
   assign store_query_name = name_reg_r;

   always_comb
   begin
      go = reg_wr && reg_addr == LTFU_OFF_CMD && reg_wdata[LTFU_CMD_GO_BIT];
      whole = reg_wdata[LTFU_CMD_WHOLE_BIT];
      target = reg_wdata[LTFU_CMD_TARGET_LSB +: 4];
      fmt = reg_wdata[LTFU_CMD_FMT_LSB +: 5];
      // fmt[4:3] comp code, fmt[2:0] element type
      fmt_ok = (fmt[4:3] != 2'd2) || fmt[2:0] == LTFU_T_FLOAT || fmt[2:0] == LTFU_T_INT
               || fmt[2:0] == LTFU_T_UINT_ANY;
      eff_off = whole ? 32'h0000_0000 : off_reg_r;
      eff_len = whole ? store_size : len_reg_r;
      end_sum = {1'b0, eff_off} + {1'b0, eff_len};
      sz_ok = !eff_off[31] && !eff_len[31] && eff_len != 32'h0000_0000
              && end_sum <= {1'b0, store_size};
      raw_count = eff_len / ({29'h0000_0000, ltfu_esize(fmt[2:0])} * ({30'h0000_0000, fmt[4:3]} + 32'd1));
      name_reg_nxt = name_reg_r;
      off_reg_nxt = off_reg_r;
      len_reg_nxt = len_reg_r;
      bind_nxt = bind_r;
      att_name_nxt = att_name_r;
      att_off_nxt = att_off_r;
      att_len_nxt = att_len_r;
      att_fmt_nxt = att_fmt_r;
      attached_nxt = attached_r;
      count_nxt = count_r;
      err_nxt = err_r;
      if (reg_wr)
      begin
         unique case (reg_addr)
            LTFU_OFF_NAME: name_reg_nxt = reg_wdata;
            LTFU_OFF_OFFSET: off_reg_nxt = reg_wdata;
            LTFU_OFF_LENGTH: len_reg_nxt = reg_wdata;
            LTFU_OFF_BIND: bind_nxt = reg_wdata;
            default: ;
         endcase
      end
      if (go)
      begin
         // errors leave attachment untouched
         if (target != LTFU_TARGET_LINEAR || !fmt_ok)
            err_nxt = LTFU_ERR_BAD_SEL;
         else if (name_reg_r != 32'h0000_0000 && !store_exists)
            err_nxt = LTFU_ERR_BAD_ACTION;
         else if (name_reg_r == 32'h0000_0000)
         begin
            err_nxt = LTFU_ERR_NONE;
            attached_nxt = 1'b0;
            att_name_nxt = 32'h0000_0000;
            att_off_nxt = 32'h0000_0000;
            att_len_nxt = 32'h0000_0000;
            att_fmt_nxt = fmt;
            count_nxt = 32'h0000_0000;
         end
         else if (!sz_ok || (eff_off % LTFU_START_ALIGN) != 32'h0000_0000)
            err_nxt = LTFU_ERR_RANGE;
         else
         begin
            err_nxt = LTFU_ERR_NONE;
            attached_nxt = 1'b1;
            att_name_nxt = name_reg_r;
            att_off_nxt = eff_off;
            att_len_nxt = eff_len;
            att_fmt_nxt = fmt;
            count_nxt = raw_count > LTFU_MAX_TEXELS ? LTFU_MAX_TEXELS : raw_count;
         end
      end
      unique case (reg_addr)
         LTFU_OFF_NAME: rdata_nxt = att_name_r;
         LTFU_OFF_OFFSET: rdata_nxt = att_off_r;
         LTFU_OFF_LENGTH: rdata_nxt = att_len_r;
         LTFU_OFF_STATUS: rdata_nxt = {23'h00_0000, att_fmt_r, attached_r, 1'b0, err_r};
         LTFU_OFF_BIND: rdata_nxt = bind_r;
         LTFU_OFF_COUNT: rdata_nxt = count_r;
         default: rdata_nxt = 32'h0000_0000;
      endcase
      if (!reg_rd)
         rdata_nxt = 32'h0000_0000;
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         name_reg_r <= '0; off_reg_r <= '0; len_reg_r <= '0; bind_r <= '0;
         att_name_r <= '0; att_off_r <= '0; att_len_r <= '0; att_fmt_r <= '0;
         attached_r <= 1'b0; count_r <= '0; err_r <= LTFU_ERR_NONE; rdata_r <= '0;
      end
      else
      begin
         name_reg_r <= name_reg_nxt; off_reg_r <= off_reg_nxt; len_reg_r <= len_reg_nxt;
         bind_r <= bind_nxt; att_name_r <= att_name_nxt; att_off_r <= att_off_nxt;
         att_len_r <= att_len_nxt; att_fmt_r <= att_fmt_nxt; attached_r <= attached_nxt;
         count_r <= count_nxt; err_r <= err_nxt; rdata_r <= rdata_nxt;
      end
   end
   assign reg_rdata = rdata_r;

   // ==========================================================
   // fetch sequencer: one store word per component
   typedef enum logic [1:0] {LTFU_IDLE, LTFU_READ, LTFU_DONE} ltfu_state_e;
   ltfu_state_e st_r, st_nxt;
   logic [1:0] comp_r, comp_nxt, ncomp;
   logic [31:0] elem_r, elem_nxt;
   logic [127:0] rgba_r, rgba_nxt;
   logic valid_r, valid_nxt, rd_r, rd_nxt;
   logic [31:0] addr_r, addr_nxt, byte_addr;
   logic [1:0] rd_comp_r, rd_comp_nxt;
   logic [1:0] rd_lane_r, rd_lane_nxt;
   logic pend_r, pend_nxt;
   logic [1:0] pend_comp_r, pend_comp_nxt, pend_lane_r, pend_lane_nxt;
   logic [1:0] kind_r, kind_nxt;
   logic [31:0] ext, conv;
   logic [2:0] esz;

   // unsigned normalized to float, b bits: value / (2^b - 1)
   function automatic logic [31:0] ltfu_unorm(input logic [15:0] v, input logic wide);
      logic [31:0] q;
      logic [7:0] e;
      logic [4:0] p;
      q = 32'h0000_0000; e = 8'h00; p = 5'd0;
      if (v == 16'h0000)
         ltfu_unorm = 32'h0000_0000;
      else
      begin
         // fraction v/(2^b-1) = v*2^-b*(1+2^-b+2^-2b...) in fixed point
         q = wide ? {v, 16'h0000} + {16'h0000, v} : {v[7:0], 24'h00_0000} + {8'h00, v[7:0], 16'h0000}
             + {16'h0000, v[7:0], 8'h00} + {24'h00_0000, v[7:0]};
         if (q[31] == 1'b0 && v != (wide ? 16'hFFFF : 16'h00FF))
         begin
            for (int i = 31; i >= 0; i--)
               if (q[i] && p == 5'd0 && i != 0)
                  p = 5'(31 - i);
         end
         if (v == (wide ? 16'hFFFF : 16'h00FF))
            ltfu_unorm = LTFU_ONE_F32;
         else
         begin
            q = q << p;
            e = 8'd126 - 8'(p);
            ltfu_unorm = {1'b0, e, q[30:8]};
         end
      end
   endfunction : ltfu_unorm

   always_comb
   begin
      esz = ltfu_esize(att_fmt_r[2:0]);
      ncomp = att_fmt_r[4:3];
      byte_addr = att_off_r + elem_r * 32'(esz);
      unique case (esz)
         3'd1: ext = att_fmt_r[2:0] == LTFU_T_BYTE
                     ? {{24{mem_rdata[8*pend_lane_r+7]}}, mem_rdata[8*pend_lane_r +: 8]}
                     : {24'h00_0000, mem_rdata[8*pend_lane_r +: 8]};
         3'd2: ext = att_fmt_r[2:0] == LTFU_T_SHORT
                     ? {{16{mem_rdata[16*pend_lane_r[1]+15]}}, mem_rdata[16*pend_lane_r[1] +: 16]}
                     : {16'h0000, mem_rdata[16*pend_lane_r[1] +: 16]};
         default: ext = mem_rdata;
      endcase
      unique case (att_fmt_r[2:0])
         LTFU_T_UB_NORM: conv = ltfu_unorm({8'h00, ext[7:0]}, 1'b0);
         LTFU_T_US_NORM: conv = ltfu_unorm(ext[15:0], 1'b1);
         // no signed normalized format exists: signed types stay integers, half passes raw bits
         default: conv = ext;
      endcase
      st_nxt = st_r; comp_nxt = comp_r; elem_nxt = elem_r; rgba_nxt = rgba_r;
      valid_nxt = 1'b0; rd_nxt = 1'b0; addr_nxt = addr_r; pend_nxt = rd_r;
      rd_comp_nxt = rd_comp_r; rd_lane_nxt = rd_lane_r;
      // the word lands a cycle after its read, so slot and lane follow it one stage later
      pend_comp_nxt = rd_comp_r; pend_lane_nxt = rd_lane_r;
      kind_nxt = att_fmt_r[2:0] == LTFU_T_UINT_ANY ? LTFU_K_UINT
                 : (att_fmt_r[2:0] >= LTFU_T_BYTE ? LTFU_K_SINT : LTFU_K_FLOAT);
      if (pend_r)
         rgba_nxt[32*pend_comp_r +: 32] = conv;
      unique case (st_r)
         LTFU_IDLE:
            if (fetch_req)
            begin
               // out of range or detached gives whatever is read
               elem_nxt = fetch_index * (32'(ncomp) + 32'd1);
               comp_nxt = 2'd0;
               rgba_nxt = {LTFU_ONE_F32, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
               if (att_fmt_r[2:0] >= LTFU_T_BYTE)
                  rgba_nxt[127:96] = 32'h0000_0001;
               st_nxt = LTFU_READ;
            end
         LTFU_READ:
         begin
            rd_nxt = 1'b1;
            addr_nxt = {byte_addr[31:2], 2'b00};
            rd_lane_nxt = byte_addr[1:0];
            rd_comp_nxt = comp_r;
            elem_nxt = elem_r + 32'd1;
            comp_nxt = comp_r + 2'd1;
            if (comp_r == ncomp)
               st_nxt = LTFU_DONE;
         end
         LTFU_DONE:
            if (!pend_r && !rd_r)
            begin
               valid_nxt = 1'b1;
               st_nxt = LTFU_IDLE;
            end
         default: st_nxt = LTFU_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r <= LTFU_IDLE; comp_r <= '0; elem_r <= '0; rgba_r <= '0; valid_r <= 1'b0;
         rd_r <= 1'b0; addr_r <= '0; pend_r <= 1'b0; rd_comp_r <= '0; rd_lane_r <= '0;
         pend_comp_r <= '0; pend_lane_r <= '0; kind_r <= '0;
      end
      else
      begin
         st_r <= st_nxt; comp_r <= comp_nxt; elem_r <= elem_nxt; rgba_r <= rgba_nxt;
         valid_r <= valid_nxt; rd_r <= rd_nxt; addr_r <= addr_nxt; pend_r <= pend_nxt;
         rd_comp_r <= rd_comp_nxt; rd_lane_r <= rd_lane_nxt;
         pend_comp_r <= pend_comp_nxt; pend_lane_r <= pend_lane_nxt; kind_r <= kind_nxt;
      end
   end

   assign fetch_valid = valid_r;
   assign fetch_rgba = rgba_r;
   assign mem_rd = rd_r;
   assign mem_addr = addr_r;
   assign fetch_kind = kind_r;
endmodule : ltfu_core

// File: ltfu_pkg.sv
// package: constants, formats and register map of the linear texel fetch unit
package ltfu_pkg;
   localparam logic [3:0] LTFU_OFF_CMD = 4'h0;
   localparam logic [3:0] LTFU_OFF_NAME = 4'h1;
   localparam logic [3:0] LTFU_OFF_OFFSET = 4'h2;
   localparam logic [3:0] LTFU_OFF_LENGTH = 4'h3;
   localparam logic [3:0] LTFU_OFF_STATUS = 4'h4;
   localparam logic [3:0] LTFU_OFF_BIND = 4'h5;
   localparam logic [3:0] LTFU_OFF_COUNT = 4'h6;
   // command register fields
   localparam int LTFU_CMD_GO_BIT = 0;
   localparam int LTFU_CMD_WHOLE_BIT = 1;
   localparam int LTFU_CMD_TARGET_LSB = 4;
   localparam int LTFU_CMD_FMT_LSB = 8;
   localparam logic [3:0] LTFU_TARGET_LINEAR = 4'h1;
   localparam logic [31:0] LTFU_START_ALIGN = 32'h0000_0010;
   localparam logic [31:0] LTFU_MAX_TEXELS = 32'h0001_0000;
   localparam logic [1:0] LTFU_ERR_NONE = 2'h0;
   localparam logic [1:0] LTFU_ERR_BAD_SEL = 2'h1;
   localparam logic [1:0] LTFU_ERR_BAD_ACTION = 2'h2;
   localparam logic [1:0] LTFU_ERR_RANGE = 2'h3;
   localparam logic [31:0] LTFU_ONE_F32 = 32'h3F80_0000;
   // format code = {comp_code[1:0], type[2:0]}, comp_code 0..3 = 1,2,3,4 components
   typedef enum logic [2:0] {
      LTFU_T_UB_NORM, LTFU_T_US_NORM, LTFU_T_HALF, LTFU_T_FLOAT,
      LTFU_T_BYTE, LTFU_T_SHORT, LTFU_T_INT, LTFU_T_UINT_ANY
   } ltfu_type_e;
   typedef enum logic [1:0] {LTFU_K_FLOAT, LTFU_K_SINT, LTFU_K_UINT} ltfu_kind_e;
endpackage : ltfu_pkg

// File: ltfu_store_model.sv
// store directory and word memory on the far side of the fetch unit
`timescale 1ns/1ns
module ltfu_store_model
(
   input wire logic mclk,
   input wire logic [31:0] store_query_name,
   output logic store_exists,
   output logic [31:0] store_size,
   input wire logic mem_rd,
   input wire logic [31:0] mem_addr,
   output logic [31:0] mem_rdata,
   input wire logic wr_en,
   input wire logic [7:0] wr_idx,
   input wire logic [31:0] wr_data
);
   logic [31:0] mem_r [256];
   // =====
   // stores 1 to 3 exist, store 3 is large enough to force clamping
   always_comb
   begin
      store_exists = store_query_name inside {32'h1, 32'h2, 32'h3};
      case (store_query_name)
         32'h1: store_size = 32'h100;
         32'h2: store_size = 32'h40;
         32'h3: store_size = 32'h0010_0000;
         default: store_size = 32'h0;
      endcase
   end
   // lines toggle between reads so a stale word never passes for fresh
   always @(posedge mclk)
   begin
      if (wr_en)
         mem_r[wr_idx] <= wr_data;
      mem_rdata <= mem_rd ? mem_r[mem_addr[9:2]] : ~mem_rdata;
   end
endmodule : ltfu_store_model

// File: ltfu_core_chk.sv
// checker on the ports of the linear texel fetch unit
`timescale 1ns/1ns
module ltfu_core_chk
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [31:0] store_query_name,
   input wire logic fetch_req,
   input wire logic fetch_valid,
   input wire logic [127:0] fetch_rgba,
   input wire logic [1:0] fetch_kind,
   input wire logic mem_rd,
   input wire logic [31:0] mem_addr
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   // =====
   // a fetch is outstanding from its request until its answer
   logic busy_r;
   logic busy_nxt;
   always_comb
      busy_nxt = fetch_valid ? 1'b0 : (busy_r | fetch_req);
   always_ff @(posedge mclk or negedge arst_n)
      if (!arst_n)
         busy_r <= 1'b0;
      else
         busy_r <= busy_nxt;
   a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not zero outside a read answer");
   a_fetch_answer: assert property (fetch_req && !busy_r |-> ##[1:12] fetch_valid)
      else $error("fetch not answered in time");
   a_valid_pulse: assert property (fetch_valid |=> !fetch_valid)
      else $error("fetch answer longer than one cycle");
   a_valid_cause: assert property (fetch_valid |-> busy_r)
      else $error("fetch answer without request");
   a_mem_aligned: assert property (mem_rd |-> mem_addr[1:0] == 2'b00)
      else $error("store read not word aligned");
   a_mem_cause: assert property (mem_rd |-> busy_r || fetch_req)
      else $error("store read outside a fetch");
   a_kind_legal: assert property (fetch_valid |-> fetch_kind != 2'h3)
      else $error("illegal result kind");
   a_rgba_hold: assert property (!fetch_req && !busy_r |=> $stable(fetch_rgba))
      else $error("result changed between fetches");
   a_name_hold: assert property (!$past(reg_wr) |-> $stable(store_query_name))
      else $error("store name changed without a write");
endmodule : ltfu_core_chk
bind ltfu_core ltfu_core_chk chk (.mclk(mclk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .store_query_name(store_query_name), .fetch_req(fetch_req),
   .fetch_valid(fetch_valid), .fetch_rgba(fetch_rgba), .fetch_kind(fetch_kind),
   .mem_rd(mem_rd), .mem_addr(mem_addr));

// File: test_ltfu_core.sv
// self-checking bench of the linear texel fetch unit with a store model
`timescale 1ns/1ns
module test_ltfu_core;
   import ltfu_pkg::*;
   logic mclk, arst_n, reg_wr, reg_rd, fetch_req, fetch_valid, mem_rd, wr_en, store_exists, rd_d;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, store_query_name, store_size, fetch_index, mem_addr, mem_rdata, wr_data;
   logic [127:0] fetch_rgba;
   logic [1:0] fetch_kind;
   logic [7:0] wr_idx;
   logic [31:0] shadow [256];
   logic [63:0] q_reg [$];
   logic [129:0] q_fetch [$];
   int fail_count, checked, cycles;
   ltfu_core DUT (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .store_query_name(store_query_name), .store_exists(store_exists),
      .store_size(store_size), .fetch_req(fetch_req), .fetch_index(fetch_index), .fetch_valid(fetch_valid),
      .fetch_rgba(fetch_rgba), .fetch_kind(fetch_kind), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
   ltfu_store_model store (.mclk(mclk), .store_query_name(store_query_name), .store_exists(store_exists),
      .store_size(store_size), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .wr_en(wr_en),
      .wr_idx(wr_idx), .wr_data(wr_data));
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // =====
   // drivers
   task automatic drv(input logic w, r, input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
   endtask : drv
   task automatic rd(input logic [3:0] a, input logic [31:0] e, m = 32'hFFFF_FFFF);
      q_reg.push_back({m, e});
      drv(1'b0, 1'b1, a, 32'h0);
   endtask : rd
   task automatic attach(input logic [31:0] nm, off, len, input logic [4:0] f, input logic [3:0] tg, input logic wh);
      drv(1'b1, 1'b0, LTFU_OFF_NAME, nm);
      drv(1'b1, 1'b0, LTFU_OFF_OFFSET, off);
      drv(1'b1, 1'b0, LTFU_OFF_LENGTH, len);
      drv(1'b1, 1'b0, LTFU_OFF_CMD, {19'h0, f, tg, 2'b00, wh, 1'b1});
   endtask : attach
   task automatic bad(input logic [31:0] nm, off, len, input logic [3:0] tg, input logic [1:0] e);
      attach(nm, off, len, 5'h1F, tg, 1'b0);
      rd(LTFU_OFF_STATUS, {23'h0, 5'h1F, 2'b10, e});
   endtask : bad
   // fetch indices stay inside the attached count and a store is attached
   task automatic fetch(input logic [31:0] idx, input logic [1:0] k, input logic [127:0] e);
      int n;
      q_fetch.push_back({k, e});
      drv(1'b0, 1'b0, 4'h0, 32'h0);
      fetch_req <= 1'b1;
      fetch_index <= idx;
      @(posedge mclk);
      fetch_req <= 1'b0;
      n = 0;
      while (fetch_valid !== 1'b1 && n < 20)
      begin
         @(posedge mclk);
         n++;
      end
   endtask : fetch
   task automatic poke(input int i, input logic [31:0] d);
      @(posedge mclk);
      wr_en <= 1'b1;
      wr_idx <= i[7:0];
      wr_data <= d;
      shadow[i] = d;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask : poke
   function automatic logic [31:0] bsz(input logic [2:0] t);
      return (t inside {3'h0, 3'h4}) ? 32'h1 : (t inside {3'h3, 3'h6, 3'h7}) ? 32'h4 : 32'h2;
   endfunction : bsz
   task automatic report_and_stop;
      // a note never answered counts against the run
      if (q_reg.size() != 0 || q_fetch.size() != 0)
         fail_count++;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   // =====
   // monitor: oldest note against each result
   task automatic check_reg(input logic [63:0] x);
      checked++;
      if ((reg_rdata & x[63:32]) !== x[31:0])
      begin
         fail_count++;
         $display("mismatch reg_rdata expected %h seen %h", x[31:0], reg_rdata & x[63:32]);
      end
   endtask : check_reg
   task automatic check_fetch(input logic [129:0] y);
      checked++;
      if ({fetch_kind, fetch_rgba} !== y)
      begin
         fail_count++;
         $display("mismatch fetch expected %h seen %h", y, {fetch_kind, fetch_rgba});
      end
   endtask : check_fetch
   always @(posedge mclk)
   begin
      if (rd_d)
         check_reg(q_reg.pop_front());
      rd_d = reg_rd;
      if (fetch_valid === 1'b1)
         check_fetch(q_fetch.pop_front());
      cycles++;
      if (cycles > 6000)
      begin
         fail_count++;
         report_and_stop;
      end
   end
   initial
   begin
      logic [4:0] f, pf;
      logic ok;
      logic [31:0] w;
      int n;
      {arst_n, reg_wr, reg_rd, fetch_req, wr_en, rd_d, reg_addr, wr_idx} = '0;
      {reg_wdata, fetch_index, wr_data} = '0;
      {fail_count, checked, cycles} = '0;
      void'($urandom(90835));
      repeat (3) @(posedge mclk);
      arst_n <= 1'b1;
      for (int i = 0; i < 256; i++)
         poke(i, (i == 6) ? 32'h00FF_00FF : $urandom);
      rd(LTFU_OFF_STATUS, 32'h0);
      attach(32'h1, 32'h10, 32'h40, 5'h18, LTFU_TARGET_LINEAR, 1'b0);
      rd(LTFU_OFF_STATUS, 32'h188);
      rd(LTFU_OFF_OFFSET, 32'h10);
      rd(LTFU_OFF_COUNT, 32'h10);
      fetch(32'h2, LTFU_K_FLOAT, {32'h0, LTFU_ONE_F32, 32'h0, LTFU_ONE_F32});
      attach(32'h1, 32'h0, 32'h100, 5'h07, LTFU_TARGET_LINEAR, 1'b0);
      repeat (4)
      begin
         n = $urandom_range(63);
         fetch(n, LTFU_K_UINT, {32'h1, 64'h0, shadow[n]});
      end
      attach(32'h1, 32'h0, 32'hC0, 5'h16, LTFU_TARGET_LINEAR, 1'b0);
      rd(LTFU_OFF_COUNT, 32'h10);
      fetch(32'h5, LTFU_K_SINT, {32'h1, shadow[17], shadow[16], shadow[15]});
      attach(32'h1, 32'h0, 32'h40, 5'h0D, LTFU_TARGET_LINEAR, 1'b0);
      w = shadow[3];
      fetch(32'h3, LTFU_K_SINT, {32'h1, 32'h0, {{16{w[31]}}, w[31:16]}, {{16{w[15]}}, w[15:0]}});
      pf = 5'h0D;
      for (int c = 0; c < 32; c++)
      begin
         f = c[4:0];
         ok = f[4:3] != 2'b10 || f[2:0] inside {3'h3, 3'h6, 3'h7};
         attach(32'h2, 32'h4, 32'h0, f, LTFU_TARGET_LINEAR, 1'b1);
         pf = ok ? f : pf;
         rd(LTFU_OFF_STATUS, {23'h0, pf, 2'b10, ok ? 2'h0 : 2'h1});
         if (ok)
            rd(LTFU_OFF_COUNT, 32'h40 / (f[4:3] + 32'h1) / bsz(f[2:0]));
      end
      bad(32'h2, 32'h0, 32'h10, 4'h2, LTFU_ERR_BAD_SEL);
      bad(32'h9, 32'h0, 32'h10, LTFU_TARGET_LINEAR, LTFU_ERR_BAD_ACTION);
      bad(32'h1, 32'h8, 32'h10, LTFU_TARGET_LINEAR, LTFU_ERR_RANGE);
      bad(32'h1, 32'h0, 32'h0, LTFU_TARGET_LINEAR, LTFU_ERR_RANGE);
      bad(32'h1, 32'hFFFF_FFF0, 32'h10, LTFU_TARGET_LINEAR, LTFU_ERR_RANGE);
      bad(32'h1, 32'h40, 32'hD0, LTFU_TARGET_LINEAR, LTFU_ERR_RANGE);
      rd(LTFU_OFF_LENGTH, 32'h40);
      attach(32'h2, 32'h0, 32'h0, 5'h1B, LTFU_TARGET_LINEAR, 1'b1);
      fetch(32'h3, LTFU_K_FLOAT, {shadow[15], shadow[14], shadow[13], shadow[12]});
      drv(1'b1, 1'b0, LTFU_OFF_BIND, 32'h1);
      rd(LTFU_OFF_BIND, 32'h1);
      drv(1'b0, 1'b0, 4'h0, 32'h0);
      poke(13, ~shadow[13]);
      fetch(32'h3, LTFU_K_FLOAT, {shadow[15], shadow[14], shadow[13], shadow[12]});
      attach(32'h3, 32'h0, 32'h0, 5'h04, LTFU_TARGET_LINEAR, 1'b1);
      rd(LTFU_OFF_COUNT, LTFU_MAX_TEXELS);
      attach(32'h0, 32'h10, 32'h20, 5'h1B, LTFU_TARGET_LINEAR, 1'b0);
      rd(LTFU_OFF_LENGTH, 32'h0);
      rd(LTFU_OFF_OFFSET, 32'h0);
      rd(LTFU_OFF_STATUS, 32'h0, 32'hB);
      drv(1'b0, 1'b0, 4'h0, 32'h0);
      repeat (3) @(posedge mclk);
      report_and_stop;
   end
endmodule : test_ltfu_core
